// >>> core/soft_serial_tx.sv
// soft serial transmitter with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module soft_serial_tx #(
   parameter int unsigned MS_CYCLES = soft_serial_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial line
   output logic tx_out,
   output logic tx_oe,
   input wire logic flow_in,
   // status
   output logic busy
);
   typedef struct packed {
      soft_serial_pkg::fsm_t fsm;
      logic [31:0] hrdata;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic src_const;
      logic flow_en;
      logic [15:0] mode;
      logic [8:0] count;
      logic [8:0] length;
      logic [15:0] pace;
      logic [3:0] width;
      logic [7:0] base;
      logic [7:0] mem_addr;
      logic mem_we;
      logic [7:0] mem_waddr;
      logic [7:0] mem_wdata;
      logic [7:0] rd_addr;
      logic [8:0] idx;
      logic [8:0] sent;
      logic [19:0] bit_cycles;
      logic [19:0] bit_cnt;
      logic [3:0] bit_idx;
      logic [3:0] nbits;
      logic [9:0] frame;
      logic [15:0] pace_cnt;
      logic [15:0] ms_cnt;
      logic tx_out;
      logic tx_oe;
      logic busy;
      logic ready;
   } state_t;

   state_t s;
   state_t n;
   logic [7:0] mem_rdata;
   logic [7:0] bus_offset;
   logic [31:0] read_value;

   soft_serial_mem #(
      .AW(8),
      .DW(8)
   ) mem (
      .clock(clock),
      .rst(rst),
      .we(s.mem_we),
      .waddr(s.mem_waddr),
      .wdata(s.mem_wdata),
      .raddr(s.rd_addr),
      .rdata(mem_rdata)
   );

   assign bus_offset = haddr[7:0];

   // register read mux, sampled in the address phase so data stand in the data phase
   always_comb begin
      read_value = '0;
      case (bus_offset)
         soft_serial_pkg::REG_CTRL: begin
            read_value[soft_serial_pkg::CTRL_CONST] = s.src_const;
            read_value[soft_serial_pkg::CTRL_FLOW] = s.flow_en;
         end
         soft_serial_pkg::REG_MODE: read_value[15:0] = s.mode;
         soft_serial_pkg::REG_COUNT: read_value[8:0] = s.count;
         soft_serial_pkg::REG_LENGTH: read_value[8:0] = s.length;
         soft_serial_pkg::REG_PACE: read_value[15:0] = s.pace;
         soft_serial_pkg::REG_WIDTH: read_value[3:0] = s.width;
         soft_serial_pkg::REG_BASE: read_value[7:0] = s.base;
         soft_serial_pkg::REG_MEM_ADDR: read_value[7:0] = s.mem_addr;
         soft_serial_pkg::REG_STATUS: begin
            read_value[soft_serial_pkg::STAT_BUSY] = s.busy;
            read_value[soft_serial_pkg::STAT_FLOW_WAIT] = (s.fsm == soft_serial_pkg::ST_FLOW);
            read_value[soft_serial_pkg::STAT_SENT_LSB +: 9] = s.sent;
         end
         default: read_value = '0;
      endcase
   end

   always_comb begin
      logic start;
      logic inv;
      logic par_en;
      logic go;
      logic done_byte;
      logic advance;
      logic [8:0] limit;
      logic [8:0] idx_next;
      logic [3:0] dbits;
      logic par_bit;
      logic [9:0] fr;
      logic level;
      logic pin;
      start = 1'b0;
      inv = s.mode[soft_serial_pkg::MODE_INV_BIT];
      par_en = s.mode[soft_serial_pkg::MODE_PAR_BIT];
      go = inv ? flow_in : ~flow_in;
      done_byte = 1'b0;
      advance = 1'b0;
      limit = (s.count != '0) ? s.count : s.length;
      idx_next = s.idx;
      dbits = par_en ? (s.width - 4'h1) : s.width;
      par_bit = 1'b0;
      fr = '1;
      level = 1'b1;
      pin = 1'b1;
      n = s;
      n.ready = 1'b1;
      n.mem_we = 1'b0;

      // bus address phase
      if (hsel && htrans[1] && hready) begin
         n.dph_wr = hwrite;
         n.dph_addr = bus_offset;
         n.hrdata = hwrite ? 32'h0000_0000 : read_value;
      end else begin
         n.dph_wr = 1'b0;
      end

      // bus data phase: configuration is frozen while a send runs
      if (s.dph_wr) begin
         case (s.dph_addr)
            soft_serial_pkg::REG_CTRL: begin
               if (!s.busy) begin
                  n.src_const = hwdata[soft_serial_pkg::CTRL_CONST];
                  n.flow_en = hwdata[soft_serial_pkg::CTRL_FLOW];
                  start = hwdata[soft_serial_pkg::CTRL_START];
               end
            end
            soft_serial_pkg::REG_MODE: if (!s.busy) n.mode = hwdata[15:0];
            soft_serial_pkg::REG_COUNT: if (!s.busy) n.count = hwdata[8:0];
            soft_serial_pkg::REG_LENGTH: if (!s.busy) n.length = hwdata[8:0];
            soft_serial_pkg::REG_PACE: if (!s.busy) n.pace = hwdata[15:0];
            soft_serial_pkg::REG_WIDTH: begin
               if (!s.busy) begin
                  if (hwdata[3:0] < soft_serial_pkg::WIDTH_MIN || hwdata[31:4] != '0) begin
                     n.width = (hwdata[31:4] != '0) ? soft_serial_pkg::WIDTH_MAX : soft_serial_pkg::WIDTH_MIN;
                  end else if (hwdata[3:0] > soft_serial_pkg::WIDTH_MAX) begin
                     n.width = soft_serial_pkg::WIDTH_MAX;
                  end else begin
                     n.width = hwdata[3:0];
                  end
               end
            end
            soft_serial_pkg::REG_BASE: if (!s.busy) n.base = hwdata[7:0];
            soft_serial_pkg::REG_MEM_ADDR: n.mem_addr = hwdata[7:0];
            soft_serial_pkg::REG_MEM_DATA: begin
               n.mem_we = 1'b1;
               n.mem_waddr = s.mem_addr;
               n.mem_wdata = hwdata[7:0];
               n.mem_addr = s.mem_addr + 8'h01;
            end
            default: n.mem_we = 1'b0;
         endcase
      end

      // character frame built from the fetched byte
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < dbits) begin
            fr[i + 1] = mem_rdata[i];
            par_bit = par_bit ^ mem_rdata[i];
         end
      end
      fr[0] = 1'b0;
      if (par_en) begin
         fr[dbits + 4'h1] = par_bit;
      end

      case (s.fsm)
         soft_serial_pkg::ST_IDLE: begin
            if (start) begin
               n.idx = '0;
               n.sent = '0;
               n.bit_cycles = 20'(soft_serial_pkg::CYC_PER_US)
                  * (20'(s.mode[soft_serial_pkg::MODE_TIME_W-1:0]) + 20'(soft_serial_pkg::BIT_US_OFFSET));
               idx_next = '0;
               advance = 1'b1;
            end
         end
         soft_serial_pkg::ST_FETCH: begin
            n.fsm = soft_serial_pkg::ST_LOAD;
         end
         soft_serial_pkg::ST_LOAD: begin
            if ((s.src_const || s.count == '0) && mem_rdata == 8'h00) begin
               n.fsm = soft_serial_pkg::ST_IDLE;
            end else begin
               n.frame = fr;
               n.nbits = s.width + soft_serial_pkg::FRAME_EXTRA;
               n.bit_idx = '0;
               n.bit_cnt = '0;
               n.fsm = s.flow_en ? soft_serial_pkg::ST_FLOW : soft_serial_pkg::ST_SEND;
            end
         end
         soft_serial_pkg::ST_FLOW: begin
            if (go) begin
               n.fsm = soft_serial_pkg::ST_SEND;
            end
         end
         soft_serial_pkg::ST_SEND: begin
            if (s.bit_cnt == s.bit_cycles - 20'h1) begin
               n.bit_cnt = '0;
               if (s.bit_idx == s.nbits - 4'h1) begin
                  done_byte = 1'b1;
               end else begin
                  n.bit_idx = s.bit_idx + 4'h1;
               end
            end else begin
               n.bit_cnt = s.bit_cnt + 20'h1;
            end
         end
         soft_serial_pkg::ST_PACE: begin
            if (s.ms_cnt == 16'(MS_CYCLES - 1)) begin
               n.ms_cnt = '0;
               if (s.pace_cnt == s.pace - 16'h1) begin
                  advance = 1'b1;
               end else begin
                  n.pace_cnt = s.pace_cnt + 16'h1;
               end
            end else begin
               n.ms_cnt = s.ms_cnt + 16'h1;
            end
         end
         default: n.fsm = soft_serial_pkg::ST_IDLE;
      endcase

      // after the stop bit: pause or go straight for the next byte
      if (done_byte) begin
         idx_next = s.idx + 9'h001;
         n.sent = s.sent + 9'h001;
         if (s.pace != '0) begin
            n.idx = idx_next;
            n.pace_cnt = '0;
            n.ms_cnt = '0;
            n.fsm = soft_serial_pkg::ST_PACE;
         end else begin
            advance = 1'b1;
         end
      end

      if (advance) begin
         n.idx = idx_next;
         // the source bit written with the start already governs the first byte
         if (!n.src_const && idx_next >= limit) begin
            n.fsm = soft_serial_pkg::ST_IDLE;
         end else begin
            n.rd_addr = s.base + idx_next[7:0];
            n.fsm = soft_serial_pkg::ST_FETCH;
         end
      end

      // line level: stop level outside the bits of a frame
      level = (n.fsm == soft_serial_pkg::ST_SEND) ? n.frame[n.bit_idx] : 1'b1;
      pin = inv ? ~level : level;
      n.tx_out = pin;
      if (s.mode[soft_serial_pkg::MODE_OPEN_BIT]) begin
         n.tx_oe = inv ? pin : ~pin;
      end else begin
         n.tx_oe = 1'b1;
      end
      n.busy = (n.fsm != soft_serial_pkg::ST_IDLE);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '{
            fsm: soft_serial_pkg::ST_IDLE,
            mode: soft_serial_pkg::MODE_9600_8N,
            count: soft_serial_pkg::COUNT_RESET,
            length: soft_serial_pkg::LENGTH_RESET,
            pace: soft_serial_pkg::PACE_RESET,
            width: soft_serial_pkg::WIDTH_DEFAULT,
            base: soft_serial_pkg::BASE_RESET,
            frame: '1,
            default: '0
         };
      end else begin
         s <= n;
      end
   end

   // ready rises one edge after reset; from then on no transfer is stretched and every answer is okay
   assign hreadyout = s.ready;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign tx_out = s.tx_out;
   assign tx_oe = s.tx_oe;
   assign busy = s.busy;
endmodule
`default_nettype wire

// >>> core/soft_serial_pkg.sv
// constants, register map and state codes of the soft serial transmitter
// Contract
// - no byte count: send elements in order until array end or a zero element
// - byte count n: send exactly the first n elements, any value included
// - constant string: send until a zero byte, forever if none
// - pace value: wait that many milliseconds after every character
// - no pace: bytes follow back to back, at least one stop bit apart
// - during a pace interval the line rests at the stop level
// - flow control: data pin output, flow pin input, wait for go before sending
// - flow pin go level: high when inverted, low when non-inverted
// - flow permission is checked again before every byte
// - open modes drive the data pin for one level only, release for the other
// - open inverted drives high and releases low; non-inverted drives low, releases high
// - mode code sets rate, polarity, format; 84 and 16468 give 9600 8N
// - even parity makes the count of ones over data and parity even
// - character width 4 to 8 bits, default 8; parity takes one of them
package soft_serial_pkg;
   // clock and timing
   localparam int unsigned CLOCK_HZ = 20_000_000;
   localparam int unsigned HZ_PER_MHZ = 1_000_000;
   localparam int unsigned CYC_PER_US = CLOCK_HZ / HZ_PER_MHZ;
   localparam int unsigned US_PER_MS = 1000;
   localparam int unsigned MS_CYCLES = CYC_PER_US * US_PER_MS;
   localparam int unsigned BIT_US_OFFSET = 20;
   // mode code fields
   localparam int MODE_TIME_W = 13;
   localparam int MODE_PAR_BIT = 13;
   localparam int MODE_INV_BIT = 14;
   localparam int MODE_OPEN_BIT = 15;
   localparam logic [15:0] MODE_9600_8N = 16'h0054;
   localparam logic [15:0] MODE_9600_8N_INV = 16'h4054;
   // character width
   localparam logic [3:0] WIDTH_MIN = 4'h4;
   localparam logic [3:0] WIDTH_MAX = 4'h8;
   localparam logic [3:0] WIDTH_DEFAULT = 4'h8;
   localparam logic [3:0] FRAME_EXTRA = 4'h2;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam logic [7:0] REG_LENGTH = 8'h0C;
   localparam logic [7:0] REG_PACE = 8'h10;
   localparam logic [7:0] REG_WIDTH = 8'h14;
   localparam logic [7:0] REG_BASE = 8'h18;
   localparam logic [7:0] REG_MEM_ADDR = 8'h1C;
   localparam logic [7:0] REG_MEM_DATA = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h24;
   // control and status bits
   localparam int CTRL_START = 0;
   localparam int CTRL_CONST = 1;
   localparam int CTRL_FLOW = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FLOW_WAIT = 1;
   localparam int STAT_SENT_LSB = 8;
   // reset values
   localparam logic [8:0] LENGTH_RESET = 9'h100;
   localparam logic [8:0] COUNT_RESET = 9'h000;
   localparam logic [15:0] PACE_RESET = 16'h0000;
   localparam logic [7:0] BASE_RESET = 8'h00;
   // sequencer states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_LOAD = 6'h04,
      ST_FLOW = 6'h08,
      ST_SEND = 6'h10,
      ST_PACE = 6'h20
   } fsm_t;
endpackage

// >>> core/soft_serial_mem.sv
// byte store for array and constant strings, registered read port
`timescale 1ns/1ns
`default_nettype none
module soft_serial_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // the array itself has no reset; software fills it before a send
   always_ff @(posedge clock) begin
      if (we) begin
         store[waddr] <= wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= store[raddr];
      end
   end
endmodule
`default_nettype wire

// >>> verif/soft_serial_tx_props.sv
// port-level properties of the soft serial transmitter
`timescale 1ns/1ns
`default_nettype none
module soft_serial_tx_props (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // line
   input wire logic tx_out,
   input wire logic tx_oe,
   input wire logic busy
);
   logic alive, aph, st_req, lvl, flow_en;
   logic [7:0] aadr;
   logic [15:0] mode;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   assign lvl = tx_out != mode[14];
   assign st_req = aph && aadr == soft_serial_pkg::REG_CTRL && hwdata[0];
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alive <= 1'b0;
         aph <= 1'b0;
         aadr <= 8'h00;
         mode <= soft_serial_pkg::MODE_9600_8N;
         flow_en <= 1'b0;
      end else begin
         alive <= 1'b1;
         aph <= hsel && htrans[1] && hready && hwrite;
         aadr <= haddr[7:0];
         // config writes are dropped while a send runs
         if (aph && !busy && aadr == soft_serial_pkg::REG_MODE) begin
            mode <= hwdata[15:0];
         end
         if (aph && !busy && aadr == soft_serial_pkg::REG_CTRL) begin
            flow_en <= hwdata[2];
         end
      end
   end
   sequence s_start_bit;
      lvl ##[1:4] (!lvl)[*8];
   endsequence
   property p_bus;
      alive |-> hreadyout && !hresp;
   endproperty
   a_bus: assert property (p_bus) else $error("bus not ready or not okay");
   property p_start;
      st_req && !busy |=> busy;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_cause;
      $rose(busy) |-> $past(st_req);
   endproperty
   a_cause: assert property (p_cause) else $error("busy without start");
   property p_frame;
      $rose(busy) && !flow_en |-> s_start_bit;
   endproperty
   a_frame: assert property (p_frame) else $error("start bit missing");
   property p_end;
      $fell(busy) |-> lvl && $past(lvl, 8);
   endproperty
   a_end: assert property (p_end) else $error("busy ended off stop level");
   property p_idle;
      alive && !busy && !$past(busy) && mode == $past(mode, 2) |-> lvl;
   endproperty
   a_idle: assert property (p_idle) else $error("line not idle");
   property p_open;
      mode[15] && mode == $past(mode, 2) |-> tx_oe == !lvl;
   endproperty
   a_open: assert property (p_open) else $error("open drive level wrong");
   property p_pp;
      alive && !mode[15] && mode == $past(mode, 2) |-> tx_oe;
   endproperty
   a_pp: assert property (p_pp) else $error("push-pull not driving");
endmodule
`default_nettype wire

// >>> verif/serial_rx_model.sv
// receiving end: samples frames mid-bit and drives the flow pin
`timescale 1ns/1ns
`default_nettype none
module serial_rx_model (
   // clock
   input wire logic clock,
   // line side
   input wire logic line,
   input wire logic inv,
   input wire logic go,
   output logic flow,
   // frame shape
   input wire logic [15:0] bitc,
   input wire logic [3:0] nb,
   // frame, stop bit on top
   output logic [9:0] rxb,
   output logic stb
);
   assign flow = go ^ !inv;
   initial begin
      stb = 1'b0;
      rxb = 10'h000;
      forever begin
         @(posedge clock);
         if ((line ^ inv) === 1'b0) begin
            repeat (bitc / 2) @(posedge clock);
            // a glitch on a mode change is not a start bit
            if ((line ^ inv) !== 1'b0) continue;
            rxb = 10'h000;
            for (int i = 0; i < nb; i++) begin
               repeat (bitc) @(posedge clock);
               rxb[i] = line ^ inv;
            end
            repeat (bitc) @(posedge clock);
            rxb[9] = line ^ inv;
            stb <= 1'b1;
            @(posedge clock);
            stb <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/soft_serial_transmitter_tb_top.sv
// self-checking bench for the soft serial transmitter
`timescale 1ns/1ns
`default_nettype none
module soft_serial_transmitter_tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic inv = 1'b0;
   logic go = 1'b1;
   logic [15:0] bitc = 16'h0820;
   logic [3:0] nb = 4'h8;
   logic hready, hresp, busy, tx_out, tx_oe, flow_in, stb, line;
   logic [31:0] hrdata, rd;
   logic [9:0] rxb;
   logic [9:0] rq[$];
   int tq[$];
   int cyc = 0;
   int t0 = 0;
   int n_mismatch = 0;
   int n_compared = 0;
   // released pin sits at the pull level, which is the idle level
   assign line = tx_oe ? tx_out : !inv;
   always #25 clock = !clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (stb === 1'b1) begin
         rq.push_back(rxb);
         tq.push_back(cyc);
      end
   end
   soft_serial_tx #(.MS_CYCLES(50)) u_dut (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .tx_out(tx_out), .tx_oe(tx_oe), .flow_in(flow_in), .busy(busy));
   serial_rx_model u_rx (.clock(clock), .line(line), .inv(inv), .go(go), .flow(flow_in), .bitc(bitc), .nb(nb),
      .rxb(rxb), .stb(stb));
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hw();
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         if (hready === 1'b1) return;
      end
      n_mismatch++;
      complete_run();
   endtask
   task automatic xf(input logic [7:0] a, input logic wr, input logic [31:0] d);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hw();
      htrans <= 2'h0;
      hwdata <= d;
      hw();
      rd = hrdata;
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xf(a, 1'b0, 32'h0);
      chk(nm, rd, e);
   endtask
   task automatic ld(input logic [7:0] b, input logic [7:0] s[$]);
      xf(8'h1C, 1'b1, {24'h000000, b});
      xf(8'h18, 1'b1, {24'h000000, b});
      foreach (s[i]) xf(8'h20, 1'b1, {24'h000000, s[i]});
   endtask
   task automatic st(input logic [31:0] c);
      rq.delete();
      tq.delete();
      xf(8'h00, 1'b1, c);
      t0 = cyc;
   endtask
   task automatic wt();
      // busy shows only one edge after the start edge
      @(posedge clock);
      for (int i = 0; i < 60000 && busy !== 1'b0; i++) @(posedge clock);
      if (busy !== 1'b0) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic ex(input logic [9:0] e[$]);
      chk("frames", rq.size(), e.size());
      foreach (e[i]) chk("frame", rq[i], e[i]);
   endtask
   function automatic logic [9:0] pf(input logic [7:0] b);
      return {2'b10, ^b[6:0], b[6:0]};
   endfunction
   task automatic t_reset();
      rc("mode", 8'h04, 32'h0054);
      rc("length", 8'h0C, 32'h0100);
      rc("unmapped", 8'h40, 32'h0);
      ld(8'h00, '{8'h41});
      xf(8'h08, 1'b1, 32'h1);
      st(32'h1);
      wt();
      ex('{10'h241});
      chk("period", (tq[0] - t0) inside {[19740:19800]}, 32'h1);
      rc("sent", 8'h24, 32'h100);
   endtask
   task automatic t_count();
      xf(8'h04, 1'b1, 32'h0);
      bitc = 16'h0190;
      ld(8'h10, '{8'h41, 8'h00, 8'h42, 8'h43});
      xf(8'h08, 1'b1, 32'h4);
      st(32'h1);
      xf(8'h00, 1'b1, 32'h1);
      xf(8'h08, 1'b1, 32'h1);
      wt();
      ex('{10'h241, 10'h200, 10'h242, 10'h243});
      rc("sent", 8'h24, 32'h400);
      rc("count", 8'h08, 32'h4);
   endtask
   task automatic t_term();
      xf(8'h08, 1'b1, 32'h0);
      xf(8'h0C, 1'b1, 32'h8);
      ld(8'h20, '{8'h5A, 8'h5B, 8'h00, 8'h5C});
      st(32'h1);
      wt();
      ex('{10'h25A, 10'h25B});
      xf(8'h18, 1'b1, 32'h23);
      xf(8'h0C, 1'b1, 32'h1);
      st(32'h1);
      wt();
      ex('{10'h25C});
   endtask
   task automatic t_const();
      xf(8'h14, 1'b1, 32'h9);
      rc("wide", 8'h14, 32'h8);
      xf(8'h14, 1'b1, 32'h2);
      rc("narrow", 8'h14, 32'h4);
      xf(8'h14, 1'b1, 32'h8);
      xf(8'h04, 1'b1, 32'hE000);
      // the pin takes the new polarity one edge after the write
      @(posedge clock);
      inv <= 1'b1;
      ld(8'h30, '{8'h1A, 8'h07, 8'h03, 8'h00});
      st(32'h3);
      wt();
      ex('{pf(8'h1A), pf(8'h07), pf(8'h03)});
   endtask
   task automatic t_flow();
      xf(8'h04, 1'b1, 32'h4054);
      bitc = 16'h0820;
      ld(8'h40, '{8'h55});
      xf(8'h08, 1'b1, 32'h1);
      go <= 1'b0;
      st(32'h5);
      repeat (1000) @(posedge clock);
      chk("held", rq.size(), 32'h0);
      rc("waiting", 8'h24, 32'h3);
      go <= 1'b1;
      wt();
      ex('{10'h255});
   endtask
   task automatic t_pace();
      xf(8'h04, 1'b1, 32'h8000);
      @(posedge clock);
      inv <= 1'b0;
      bitc = 16'h0190;
      xf(8'h10, 1'b1, 32'h2);
      ld(8'h50, '{8'h31, 8'h32});
      xf(8'h08, 1'b1, 32'h2);
      st(32'h5);
      wt();
      ex('{10'h231, 10'h232});
      chk("gap", (tq[1] - tq[0]) inside {[4100:4106]}, 32'h1);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_count();
      t_term();
      t_const();
      t_flow();
      t_pace();
      complete_run();
   end
endmodule
bind soft_serial_tx soft_serial_tx_props u_props (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .tx_out(tx_out), .tx_oe(tx_oe), .busy(busy));
`default_nettype wire
